// ===== src/led_status_params.svh
`ifndef LED_STATUS_PARAMS_SVH
`define LED_STATUS_PARAMS_SVH

// ****************************************
// Clock and blink timing
// ****************************************
`define CLK_HZ 40000000
`define BLINK_HALF_US 250000
`define BLINK_HALF_CYC ((`CLK_HZ / 1000000) * `BLINK_HALF_US)
`define BLINK_CNT_W 24

// ****************************************
// Indicator counts
// ****************************************
`define STATUS_LED_CNT 6
`define CHAN_LED_CNT 24
`define REAL_AXIS_CNT 8
`define GROUP_CNT 4

// ****************************************
// Register map (byte addresses)
// ****************************************
`define REG_ADDR_W 8
`define REG_DATA_W 32
`define REG_CTRL 8'h00
`define REG_MASK 8'h04
`define REG_EVENT 8'h08
`define REG_BLOCK 8'h0C
`define REG_CHAN 8'h10

// ****************************************
// Field positions and reset values
// ****************************************
`define CTRL_LAMP_TEST 0
`define CTRL_BLINK_HOLD 1
`define CTRL_W 2
`define CTRL_RESET 2'h0
`define EVT_FAILURE 0
`define EVT_WIRING 1
`define EVT_RING_LOST 2
`define EVT_AXIS_FAULT 3
`define EVT_W 4
`define EVT_RESET 4'h0
`define MASK_RESET 4'h0

`endif

// ===== src/led_status_pkg.sv
package led_status_pkg;

  // Channel condition, Gray ordered along unconfigured -> configuring -> normal
  typedef enum logic [1:0] {
    AXIS_UNCONF = 2'h0,
    AXIS_CONFIGURING = 2'h1,
    AXIS_NORMAL = 2'h3,
    AXIS_FAULTY = 2'h2
  } axis_state_e;

  typedef enum logic [1:0] {
    LED_DARK = 2'h0,
    LED_STEADY = 2'h1,
    LED_FLASH = 2'h3
  } led_mode_e;

  typedef struct packed {
    logic running;
    logic app_present;
    logic app_invalid;
    logic exec_fault;
    logic module_failure;
    logic starting;
    logic comm_fault;
    logic wiring_fault;
    logic reinit_phase;
    logic ring_traffic;
  } module_cond_s;

  typedef struct packed {
    logic spare_indicator;
    logic ring_traffic_indicator;
    logic restart_phase_indicator;
    logic external_fault;
    logic internal_fault;
    logic healthy;
  } status_leds_s;

endpackage

// ===== src/blink_divider.sv
`timescale 1ns/1ps
`include "led_status_params.svh"

module blink_divider #(
  parameter int unsigned HALF_CYC = `BLINK_HALF_CYC,
  parameter int unsigned CNT_W = `BLINK_CNT_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hold,
  output logic phase
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF_CYC - 1);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic phase_r;
  wire wrap = (cnt_r == LAST);

  // Hold freezes the phase, handy for a steady photo of the panel
  assign cnt_nxt = (hold || wrap) ? '0 : cnt_r + CNT_W'(1);
  assign phase = phase_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      phase_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      phase_r <= phase_r ^ (wrap & ~hold);
    end
  end

endmodule

// ===== src/led_driver.sv
`timescale 1ns/1ps

module led_driver (
  input wire logic core_clk,
  input wire logic rst_n,
  input led_status_pkg::led_mode_e mode,
  input wire logic phase,
  input wire logic force_on,
  output logic led
);
  import led_status_pkg::*;

  logic led_r;
  logic led_nxt;

  // One flop per lamp keeps every panel output glitch free
  assign led_nxt = force_on | (mode == LED_STEADY) | ((mode == LED_FLASH) & phase);
  assign led = led_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_r <= 1'b0;
    end else begin
      led_r <= led_nxt;
    end
  end

endmodule

// ===== src/motion_module_led_status.sv
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "led_status_params.svh"

module motion_module_led_status
  import led_status_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYC = `BLINK_HALF_CYC,
  parameter int unsigned REAL_AXES = `REAL_AXIS_CNT,
  parameter int unsigned GROUP = `GROUP_CNT
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input led_status_pkg::module_cond_s module_cond,
  input led_status_pkg::axis_state_e real_axis [REAL_AXES],
  input led_status_pkg::axis_state_e imag_axis [GROUP],
  input led_status_pkg::axis_state_e remote_axis [GROUP],
  input led_status_pkg::axis_state_e coord_set [GROUP],
  input led_status_pkg::axis_state_e follow_set [GROUP],
  input wire logic [`REG_ADDR_W-1:0] reg_addr,
  input wire logic [`REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`REG_DATA_W-1:0] reg_rdata,
  output led_status_pkg::status_leds_s status_leds,
  output logic [`CHAN_LED_CNT-1:0] chan_leds,
  output logic irq
);
  import led_status_pkg::*;

  localparam int unsigned NCHAN = REAL_AXES + 4 * GROUP;

  // ****************************************
  // Control and interrupt registers
  // ****************************************
  logic [`CTRL_W-1:0] ctrl_r;
  logic [`CTRL_W-1:0] ctrl_nxt;
  logic [`EVT_W-1:0] mask_r;
  logic [`EVT_W-1:0] mask_nxt;
  logic [`EVT_W-1:0] event_r;
  logic [`EVT_W-1:0] event_nxt;
  logic [`REG_DATA_W-1:0] rdata_r;
  logic [`REG_DATA_W-1:0] rdata_nxt;
  logic irq_r;

  wire lamp_test = ctrl_r[`CTRL_LAMP_TEST];
  wire blink_hold = ctrl_r[`CTRL_BLINK_HOLD];

  wire sel_ctrl = (reg_addr == `REG_CTRL);
  wire sel_mask = (reg_addr == `REG_MASK);
  wire sel_event = (reg_addr == `REG_EVENT);
  wire sel_block = (reg_addr == `REG_BLOCK);
  wire sel_chan = (reg_addr == `REG_CHAN);

  // ****************************************
  // Shared blink phase
  // ****************************************
  logic phase;

  blink_divider #(
    .HALF_CYC(BLINK_HALF_CYC),
    .CNT_W(`BLINK_CNT_W)
  ) u_blink (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .hold(blink_hold),
    .phase(phase)
  );

  // ****************************************
  // Status block modes
  // ****************************************
  wire normal_op = module_cond.running & module_cond.app_present & ~module_cond.app_invalid &
                   ~module_cond.exec_fault & ~module_cond.module_failure & ~module_cond.starting &
                   ~module_cond.comm_fault & ~module_cond.reinit_phase;
  wire app_problem = ~module_cond.app_present | module_cond.app_invalid | module_cond.exec_fault;
  wire int_flash = module_cond.starting | module_cond.comm_fault | app_problem;

  led_mode_e healthy_mode;
  led_mode_e int_mode;
  led_mode_e ext_mode;
  led_mode_e restart_mode;
  led_mode_e ring_mode;

  assign healthy_mode = normal_op ? LED_STEADY : LED_DARK;
  // Failure outranks the flashing causes: a dead module must not look merely busy
  assign int_mode = module_cond.module_failure ? LED_STEADY :
                    (int_flash ? LED_FLASH : LED_DARK);
  assign ext_mode = module_cond.wiring_fault ? LED_STEADY : LED_DARK;
  assign restart_mode = module_cond.reinit_phase ? LED_FLASH : LED_DARK;
  assign ring_mode = module_cond.ring_traffic ? LED_FLASH : LED_DARK;

  led_mode_e blk_mode [`STATUS_LED_CNT-1];
  logic [`STATUS_LED_CNT-2:0] blk_led;

  assign blk_mode[0] = healthy_mode;
  assign blk_mode[1] = int_mode;
  assign blk_mode[2] = ext_mode;
  assign blk_mode[3] = restart_mode;
  assign blk_mode[4] = ring_mode;

  genvar gb;
  generate
    for (gb = 0; gb < `STATUS_LED_CNT - 1; gb++) begin : g_blk
      led_driver u_drv (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .mode(blk_mode[gb]),
        .phase(phase),
        .force_on(lamp_test),
        .led(blk_led[gb])
      );
    end
  endgenerate

  // ****************************************
  // Spare lamp
  // ****************************************
  // Unused lamp: a flop held dark, excluded even from the lamp test
  logic spare_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      spare_r <= 1'b0;
    end else begin
      spare_r <= 1'b0;
    end
  end

  assign status_leds.healthy = blk_led[0];
  assign status_leds.internal_fault = blk_led[1];
  assign status_leds.external_fault = blk_led[2];
  assign status_leds.restart_phase_indicator = blk_led[3];
  assign status_leds.ring_traffic_indicator = blk_led[4];
  assign status_leds.spare_indicator = spare_r;

  // ****************************************
  // Channel bank
  // ****************************************
  axis_state_e chan_state [NCHAN];
  led_mode_e chan_mode [NCHAN];
  logic [NCHAN-1:0] chan_fault;

  genvar gr;
  generate
    for (gr = 0; gr < REAL_AXES; gr++) begin : g_real
      assign chan_state[gr] = real_axis[gr];
    end
    for (gr = 0; gr < GROUP; gr++) begin : g_grp
      assign chan_state[REAL_AXES + gr] = imag_axis[gr];
      assign chan_state[REAL_AXES + GROUP + gr] = remote_axis[gr];
      assign chan_state[REAL_AXES + 2 * GROUP + gr] = coord_set[gr];
      assign chan_state[REAL_AXES + 3 * GROUP + gr] = follow_set[gr];
    end
  endgenerate

  genvar gc;
  generate
    for (gc = 0; gc < NCHAN; gc++) begin : g_chan
      // Same encoding for axes and axis sets
      assign chan_mode[gc] = (chan_state[gc] == AXIS_NORMAL) ? LED_STEADY :
                             ((chan_state[gc] == AXIS_CONFIGURING) || (chan_state[gc] == AXIS_FAULTY)) ?
                             LED_FLASH : LED_DARK;
      assign chan_fault[gc] = (chan_state[gc] == AXIS_FAULTY);
      led_driver u_drv (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .mode(chan_mode[gc]),
        .phase(phase),
        .force_on(lamp_test),
        .led(chan_leds[gc])
      );
    end
  endgenerate

  // ****************************************
  // Event detection
  // ****************************************
  logic failure_d_r;
  logic wiring_d_r;
  logic ring_d_r;
  logic [NCHAN-1:0] axis_fault_d_r;

  // Per-channel history: a second axis failing while another is still faulty is news too
  wire [NCHAN-1:0] new_axis_fault = chan_fault & ~axis_fault_d_r;
  logic [`EVT_W-1:0] evt_hit;

  // Histories reset low: a fault present at release is reported once, a ring that never ran is not lost
  assign evt_hit[`EVT_FAILURE] = module_cond.module_failure & ~failure_d_r;
  assign evt_hit[`EVT_WIRING] = module_cond.wiring_fault & ~wiring_d_r;
  assign evt_hit[`EVT_RING_LOST] = ~module_cond.ring_traffic & ring_d_r;
  assign evt_hit[`EVT_AXIS_FAULT] = |new_axis_fault;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      failure_d_r <= 1'b0;
    end else begin
      failure_d_r <= module_cond.module_failure;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wiring_d_r <= 1'b0;
    end else begin
      wiring_d_r <= module_cond.wiring_fault;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ring_d_r <= 1'b0;
    end else begin
      ring_d_r <= module_cond.ring_traffic;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      axis_fault_d_r <= '0;
    end else begin
      axis_fault_d_r <= chan_fault;
    end
  end

  // ****************************************
  // Register access
  // ****************************************
  wire evt_read = reg_rd & sel_event;

  assign ctrl_nxt = (reg_wr && sel_ctrl) ? reg_wdata[`CTRL_W-1:0] : ctrl_r;
  assign mask_nxt = (reg_wr && sel_mask) ? reg_wdata[`EVT_W-1:0] : mask_r;
  // A new event in the clearing read cycle survives the clear
  assign event_nxt = (evt_read ? `EVT_W'(0) : event_r) | evt_hit;

  wire [`REG_DATA_W-1:0] rd_ctrl = {{(`REG_DATA_W - `CTRL_W){1'b0}}, ctrl_r};
  wire [`REG_DATA_W-1:0] rd_mask = {{(`REG_DATA_W - `EVT_W){1'b0}}, mask_r};
  wire [`REG_DATA_W-1:0] rd_event = {{(`REG_DATA_W - `EVT_W){1'b0}}, event_r};
  wire [`REG_DATA_W-1:0] rd_block = {{(`REG_DATA_W - `STATUS_LED_CNT){1'b0}}, status_leds};
  wire [`REG_DATA_W-1:0] rd_chan = {{(`REG_DATA_W - `CHAN_LED_CNT){1'b0}}, chan_leds};

  // Unmapped addresses read as zero; data stands only in the cycle after the strobe
  assign rdata_nxt = !reg_rd ? '0 :
                     sel_ctrl ? rd_ctrl :
                     sel_mask ? rd_mask :
                     sel_event ? rd_event :
                     sel_block ? rd_block :
                     sel_chan ? rd_chan : '0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= `MASK_RESET;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_r <= `EVT_RESET;
    end else begin
      event_r <= event_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Next-state terms keep irq in step with the event bit instead of one cycle behind it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(event_nxt & mask_nxt);
    end
  end

  assign reg_rdata = rdata_r;
  assign irq = irq_r;

endmodule

// ===== verif/lamp_observer.sv
`timescale 1ns/1ps
// ****
// Operator model
// ****
// A lamp seen both lit and dark within one window is read as blinking
module lamp_observer (
  input wire logic core_clk,
  input wire logic clear,
  input wire logic [29:0] lamps,
  output logic [29:0] on_seen,
  output logic [29:0] off_seen
);
  always_ff @(posedge core_clk) begin
    if (clear) begin
      on_seen <= '0;
      off_seen <= '0;
    end else begin
      on_seen <= on_seen | lamps;
      off_seen <= off_seen | ~lamps;
    end
  end
endmodule

// ===== verif/led_status_props.sv
`timescale 1ns/1ps
module led_status_props
  import led_status_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYC = 4,
  parameter int unsigned REAL_AXES = 8,
  parameter int unsigned GROUP = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input led_status_pkg::module_cond_s module_cond,
  input led_status_pkg::axis_state_e real_axis [REAL_AXES],
  input led_status_pkg::axis_state_e imag_axis [GROUP],
  input led_status_pkg::axis_state_e remote_axis [GROUP],
  input led_status_pkg::axis_state_e coord_set [GROUP],
  input led_status_pkg::axis_state_e follow_set [GROUP],
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input led_status_pkg::status_leds_s status_leds,
  input wire logic [23:0] chan_leds,
  input wire logic irq
);
  logic rdy_r;
  logic lt_r;
  logic ok;
  logic hl;
  module_cond_s c;
  // Lamp test overrides every lamp but the spare, so the others are judged only outside it
  assign ok = rdy_r && !lt_r;
  assign c = module_cond;
  assign hl = c.running && c.app_present && !c.app_invalid && !c.exec_fault && !c.module_failure
    && !c.starting && !c.comm_fault && !c.reinit_phase;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_r <= 1'b0;
      lt_r <= 1'b0;
    end else begin
      rdy_r <= 1'b1;
      if (reg_wr && reg_addr == 8'h00) begin
        lt_r <= reg_wdata[0];
      end
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // ****
  // Lamp checks
  // ****
  AST_SPARE: assert property (!status_leds.spare_indicator) else $error("spare lamp lit");
  AST_HEALTHY: assert property ($past(ok) |-> status_leds.healthy == $past(hl))
    else $error("healthy lamp wrong");
  AST_INT_FAIL: assert property ($past(ok && c.module_failure) |-> status_leds.internal_fault)
    else $error("internal lamp not lit");
  AST_INT_QUIET: assert property ($past(ok && hl) |-> !status_leds.internal_fault)
    else $error("internal lamp lit");
  AST_EXT: assert property ($past(ok) |-> status_leds.external_fault == $past(c.wiring_fault))
    else $error("external lamp wrong");
  AST_RESTART: assert property ($past(ok && !c.reinit_phase) |-> !status_leds.restart_phase_indicator)
    else $error("restart lamp lit");
  AST_RING: assert property ($past(ok && !c.ring_traffic) |-> !status_leds.ring_traffic_indicator)
    else $error("ring lamp lit");
  AST_PHASE: assert property ($past(ok && c.reinit_phase && c.ring_traffic) |->
    status_leds.restart_phase_indicator == status_leds.ring_traffic_indicator) else $error("lamps out of phase");
  AST_INT_PHASE: assert property ($past(ok && c.starting && !c.module_failure && c.reinit_phase) |->
    status_leds.internal_fault == status_leds.restart_phase_indicator) else $error("internal out of phase");
  AST_REAL: assert property ($past(ok && real_axis[0] == AXIS_UNCONF) |-> !chan_leds[0])
    else $error("real axis lamp lit");
  AST_IMAG: assert property ($past(ok && imag_axis[1] == AXIS_NORMAL) |-> chan_leds[9])
    else $error("imaginary axis lamp dark");
  AST_SETS: assert property ($past(ok && remote_axis[0] == AXIS_NORMAL && coord_set[3] == AXIS_NORMAL) |->
    chan_leds[12] && chan_leds[19]) else $error("remote or set lamp dark");
  AST_FOLLOW: assert property ($past(ok && follow_set[3] == AXIS_UNCONF) |-> !chan_leds[23])
    else $error("follower lamp lit");
endmodule
bind motion_module_led_status led_status_props #(
  .BLINK_HALF_CYC(BLINK_HALF_CYC), .REAL_AXES(REAL_AXES), .GROUP(GROUP)
) led_status_props_inst (
  .core_clk(core_clk), .rst_n(rst_n), .module_cond(module_cond), .real_axis(real_axis),
  .imag_axis(imag_axis), .remote_axis(remote_axis), .coord_set(coord_set), .follow_set(follow_set),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .status_leds(status_leds), .chan_leds(chan_leds), .irq(irq)
);

// ===== verif/test_motion_module_led_status.sv
`timescale 1ns/1ps
module test_motion_module_led_status;
  import led_status_pkg::*;
  localparam int HALF = 8;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  module_cond_s module_cond = '0;
  axis_state_e real_axis [8];
  axis_state_e imag_axis [4];
  axis_state_e remote_axis [4];
  axis_state_e coord_set [4];
  axis_state_e follow_set [4];
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  status_leds_s status_leds;
  logic [23:0] chan_leds;
  logic irq;
  logic clear = 1'b1;
  logic [29:0] on_seen;
  logic [29:0] off_seen;
  int n_errors = 0;
  int n_checks = 0;
  motion_module_led_status #(.BLINK_HALF_CYC(HALF)) motion_module_led_status_inst (
    .core_clk(core_clk), .rst_n(rst_n), .module_cond(module_cond), .real_axis(real_axis),
    .imag_axis(imag_axis), .remote_axis(remote_axis), .coord_set(coord_set), .follow_set(follow_set),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .status_leds(status_leds), .chan_leds(chan_leds), .irq(irq)
  );
  lamp_observer lamp_observer_inst (
    .core_clk(core_clk), .clear(clear), .lamps({chan_leds, status_leds}),
    .on_seen(on_seen), .off_seen(off_seen)
  );
  initial forever #12.5 core_clk = ~core_clk;
  // ****
  // Shared tasks
  // ****
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Window spans four blink half periods so any blinking lamp shows both levels
  task automatic watch();
    clear <= 1'b1;
    @(posedge core_clk);
    clear <= 1'b0;
    repeat (4 * HALF) @(posedge core_clk);
  endtask
  function automatic logic [1:0] md(input int i);
    return {on_seen[i] & off_seen[i], on_seen[i]};
  endfunction
  task automatic set_ax(input int c, input axis_state_e s);
    if (c < 8) real_axis[c] <= s;
    else if (c < 12) imag_axis[c - 8] <= s;
    else if (c < 16) remote_axis[c - 12] <= s;
    else if (c < 20) coord_set[c - 16] <= s;
    else follow_set[c - 20] <= s;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_status(input module_cond_s c, input logic [11:0] exp);
    module_cond <= c;
    watch();
    for (int i = 0; i < 6; i++) chk(md(i), exp[2*i+:2]);
    $display("status case %h done", c);
  endtask
  task automatic t_chan();
    axis_state_e s;
    for (int c = 0; c < 24; c++) set_ax(c, axis_state_e'((c + c / 4) % 4));
    watch();
    for (int c = 0; c < 24; c++) begin
      s = axis_state_e'((c + c / 4) % 4);
      chk(md(6 + c), s == AXIS_NORMAL ? 2'h1 : (s == AXIS_UNCONF ? 2'h0 : 2'h3));
    end
    $display("channel test done");
  endtask
  task automatic t_irq();
    logic [31:0] d;
    chk(irq, 1'b0);
    rd(8'h08, d);
    chk(d, 32'hF);
    rd(8'h08, d);
    chk(d, 32'h0);
    wr(8'h04, 32'h2);
    rd(8'h04, d);
    chk(d, 32'h2);
    module_cond <= 10'h320;
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b0);
    module_cond <= 10'h324;
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b1);
    rd(8'h08, d);
    chk(d, 32'h3);
    chk(irq, 1'b0);
    rd(8'hFC, d);
    chk(d, 32'h0);
    wr(8'h00, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(chan_leds, 24'hFF_FFFF);
    chk(status_leds.spare_indicator, 1'b0);
    rd(8'h10, d);
    chk(d, 32'h00FF_FFFF);
    rd(8'h0C, d);
    chk(d, 32'h0000_001F);
    wr(8'h00, 32'h2);
    module_cond <= 10'h302;
    watch();
    chk(on_seen[3] & off_seen[3], 1'b0);
    $display("register test done");
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    for (int c = 0; c < 24; c++) set_ax(c, AXIS_UNCONF);
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_status(10'h300, 12'h001);
    t_status(10'h317, 12'h3DC);
    t_status(10'h320, 12'h004);
    t_status(10'h200, 12'h00C);
    t_status(10'h308, 12'h00C);
    t_chan();
    t_irq();
    tally_and_finish();
  end
endmodule
